// *** pkg/pressure_pkg.sv ***
package pressure_pkg;

  // --------------------------------------------------------------------
  // bus target addresses and converter commands
  // --------------------------------------------------------------------
  localparam logic [7:0] CAL_RD_ADDR = 8'hA1;
  localparam logic [7:0] CAL_WR_ADDR = 8'hA0;
  localparam logic [7:0] ADC_WR_ADDR = 8'hEE;
  localparam logic [7:0] ADC_RD_ADDR = 8'hEF;
  localparam logic [7:0] CMD_PREFIX = 8'hFF;
  localparam logic [7:0] CMD_PRESSURE = 8'hF0;
  localparam logic [7:0] CMD_TEMPERATURE = 8'hE8;
  localparam logic [7:0] CMD_RESULT = 8'hFD;

  // --------------------------------------------------------------------
  // calibration memory byte addresses
  // --------------------------------------------------------------------
  localparam logic [7:0] SENSITIVITY_COEFF = 8'h10;
  localparam logic [7:0] OFFSET_COEFF = 8'h12;
  localparam logic [7:0] SENSITIVITY_TEMPCO = 8'h14;
  localparam logic [7:0] OFFSET_TEMPCO = 8'h16;
  localparam logic [7:0] REFERENCE_TEMPERATURE = 8'h18;
  localparam logic [7:0] TEMPERATURE_TEMPCO = 8'h1A;
  localparam logic [7:0] OFFSET_FINE_TUNE = 8'h1C;
  localparam logic [7:0] SENSOR_PARAM_A = 8'h1E;
  localparam logic [7:0] SENSOR_PARAM_B = 8'h1F;
  localparam logic [7:0] SENSOR_PARAM_C = 8'h20;
  localparam logic [7:0] SENSOR_PARAM_D = 8'h21;
  localparam logic [7:0] CAL_UNMAPPED = 8'h00;
  localparam logic [7:0] RESULT_PAD = 8'h00;

  // --------------------------------------------------------------------
  // serial framing and converter timing
  // --------------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [1:0] RESULT_HIGH = 2'h0;
  localparam logic [1:0] RESULT_LOW = 2'h1;
  localparam logic [1:0] RESULT_DONE = 2'h2;
  // conversion length in converter clock edges (~31 ms at 32768 Hz)
  localparam int unsigned CONV_MCLK_EDGES = 1024;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic {CONV_PRESSURE, CONV_TEMPERATURE} conv_kind_e;
  typedef enum logic {TGT_CAL, TGT_ADC} target_e;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_WR_BYTE, ST_ACK, ST_RD_BYTE, ST_MACK
  } i2c_state_e;

  // pins seen from outside the clock domain
  typedef struct packed {
    logic scl;
    logic sda;
    logic conv_clk;
    logic conv_rst_n;
  } pins_s;

endpackage

// *** verilog/pressure_converter.sv ***
`timescale 1ns/100ps
`default_nettype none
module pressure_converter
  import pressure_pkg::*;
#(
  parameter int unsigned CONV_EDGES = CONV_MCLK_EDGES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // control from the bus side
  input wire logic conv_clk_rise_in,
  input wire logic conv_enable_in,
  input wire logic start_in,
  input wire conv_kind_e kind_in,
  // sensor words
  input wire logic [15:0] raw_pressure_in,
  input wire logic [15:0] raw_temperature_in,
  // status and result
  output logic busy_out,
  output logic [15:0] result_out
);

  localparam int unsigned CW = $clog2(CONV_EDGES + 1);
  localparam logic [CW-1:0] LAST_EDGE = CW'(CONV_EDGES - 1);

  logic busy, next_busy;
  logic [CW-1:0] cnt, next_cnt;
  conv_kind_e kind, next_kind;
  logic [15:0] result, next_result;

  // --------------------------------------------------------------------
  // conversion sequencer
  // --------------------------------------------------------------------
  // held in reset while the converter reset pin is low
  always_comb begin
    next_busy = busy;
    next_cnt = cnt;
    next_kind = kind;
    next_result = result;
    if (!conv_enable_in) begin
      next_busy = 1'b0;
      next_cnt = '0;
      next_result = '0;
    end else if (start_in && !busy) begin
      next_busy = 1'b1;
      next_cnt = '0;
      next_kind = kind_in;
    end else if (busy && conv_clk_rise_in) begin
      if (cnt == LAST_EDGE) begin
        next_busy = 1'b0;
        // pressure yields the raw pressure word, else temperature
        next_result = (kind == CONV_PRESSURE) ? raw_pressure_in
                                              : raw_temperature_in;
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  // register the sequencer
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy <= 1'b0;
      cnt <= '0;
      kind <= CONV_PRESSURE;
      result <= '0;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      kind <= next_kind;
      result <= next_result;
    end
  end

  assign busy_out = busy;
  assign result_out = result;

endmodule
`default_nettype wire

// *** verilog/pressure_readout.sv ***
// Overview of operation
// - The calibration memory answers reads at 0xA1 and stores no data.
// - The converter answers 0xEE for writes and 0xEF for reads.
// - Calibration reads set a byte address, then read bytes in sequence.
// - Seven coefficients sit high byte first at 16..29, four params 30..33.
// - Results go out high byte then low; master acks, then nacks and stops.
// - Pressure conversions give raw_pressure, temperature raw_temperature.
`timescale 1ns/100ps
`default_nettype none
module pressure_readout
  import pressure_pkg::*;
#(
  parameter int unsigned CONV_EDGES = CONV_MCLK_EDGES,
  // {offset_fine_tune .. sensitivity_coeff}, index 0 last
  parameter logic [6:0][15:0] COEFFS = {16'h09C4, 16'h0F96, 16'h23E7,
    16'h01B9, 16'h0138, 16'h0E8C, 16'h74D4},
  // {param_d, param_c, param_b, param_a}
  parameter logic [3:0][7:0] PARAMS = {8'h09, 8'h04, 8'h04, 8'h01}
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // two-wire bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // converter pins
  input wire logic conv_clk_in,
  input wire logic converter_reset_n_in,
  // sensor words, same clock domain
  input wire logic [15:0] raw_pressure_in,
  input wire logic [15:0] raw_temperature_in,
  // status
  output logic conv_busy_out
);

  // --------------------------------------------------------------------
  // pin synchronisers and edge finders
  // --------------------------------------------------------------------
  pins_s pins_raw, sync1, sync2, prev;

  assign pins_raw = '{scl: scl_in, sda: sda_in,
                      conv_clk: conv_clk_in,
                      conv_rst_n: converter_reset_n_in};

  // only sync2 and later stages feed logic
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1 <= '{scl: 1'b1, sda: 1'b1, conv_clk: 1'b0, conv_rst_n: 1'b0};
      sync2 <= '{scl: 1'b1, sda: 1'b1, conv_clk: 1'b0, conv_rst_n: 1'b0};
      prev <= '{scl: 1'b1, sda: 1'b1, conv_clk: 1'b0, conv_rst_n: 1'b0};
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond, conv_clk_rise;

  // start and stop are sda edges while scl stays high
  assign scl_rise = sync2.scl && !prev.scl;
  assign scl_fall = !sync2.scl && prev.scl;
  assign start_cond = sync2.scl && prev.scl && prev.sda && !sync2.sda;
  assign stop_cond = sync2.scl && prev.scl && !prev.sda && sync2.sda;
  assign conv_clk_rise = sync2.conv_clk && !prev.conv_clk;

  // --------------------------------------------------------------------
  // calibration memory contents
  // --------------------------------------------------------------------
  // addresses outside the coefficient and param span read as a fixed pad byte
  function automatic logic [7:0] cal_byte(input logic [7:0] addr);
    logic [7:0] rel;
    logic [7:0] prel;
    rel = addr - SENSITIVITY_COEFF;
    prel = addr - SENSOR_PARAM_A;
    if (addr >= SENSITIVITY_COEFF && addr < SENSOR_PARAM_A) begin
      // even address is the high byte of the pair
      cal_byte = rel[0] ? COEFFS[rel[3:1]][7:0]
                        : COEFFS[rel[3:1]][15:8];
    end else if (addr >= SENSOR_PARAM_A && addr <= SENSOR_PARAM_D) begin
      cal_byte = PARAMS[prel[1:0]];
    end else begin
      cal_byte = CAL_UNMAPPED;
    end
  endfunction

  // --------------------------------------------------------------------
  // converter
  // --------------------------------------------------------------------
  logic conv_start;
  conv_kind_e pend_kind, next_pend_kind;
  logic [15:0] result;

  pressure_converter #(
    .CONV_EDGES(CONV_EDGES)
  ) u_conv (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .conv_clk_rise_in(conv_clk_rise),
    .conv_enable_in(sync2.conv_rst_n),
    .start_in(conv_start),
    .kind_in(pend_kind),
    .raw_pressure_in(raw_pressure_in),
    .raw_temperature_in(raw_temperature_in),
    .busy_out(conv_busy_out),
    .result_out(result)
  );

  // --------------------------------------------------------------------
  // bus target state
  // --------------------------------------------------------------------
  i2c_state_e state, next_state;
  target_e target, next_target;
  logic is_read, next_is_read;
  logic first_wr, next_first_wr;
  logic [7:0] shift, next_shift;
  logic [3:0] cnt, next_cnt;
  logic [7:0] ptr, next_ptr;
  logic [1:0] rd_idx, next_rd_idx;
  logic drive, next_drive;
  logic armed, next_armed;
  logic pend, next_pend;
  logic [7:0] load_byte;

  // byte to send next; result words go high byte then low
  always_comb begin
    if (target == TGT_CAL) begin
      load_byte = cal_byte(ptr);
    end else if (rd_idx == RESULT_HIGH) begin
      load_byte = result[15:8];
    end else if (rd_idx == RESULT_LOW) begin
      load_byte = result[7:0];
    end else begin
      load_byte = RESULT_PAD;
    end
  end

  // protocol engine; sda only changes while scl is low
  always_comb begin
    next_state = state;
    next_target = target;
    next_is_read = is_read;
    next_first_wr = first_wr;
    next_shift = shift;
    next_cnt = cnt;
    next_ptr = ptr;
    next_rd_idx = rd_idx;
    next_drive = drive;
    next_armed = armed;
    next_pend = pend;
    next_pend_kind = pend_kind;
    conv_start = 1'b0;
    if (start_cond) begin
      // repeated start keeps the memory pointer
      next_state = ST_ADDR;
      next_cnt = '0;
      next_drive = 1'b0;
    end else if (stop_cond) begin
      next_state = ST_IDLE;
      next_drive = 1'b0;
      next_armed = 1'b0;
      if (pend) begin
        // conversion begins only at the stop closing the command
        conv_start = 1'b1;
        next_pend = 1'b0;
      end
    end else begin
      case (state)
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sync2.sda};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == BYTE_BITS) begin
            next_state = ST_ACK;
            next_drive = 1'b1;
            if (state == ST_ADDR) begin
              case (shift)
                CAL_RD_ADDR: begin
                  next_target = TGT_CAL;
                  next_is_read = 1'b1;
                end
                CAL_WR_ADDR: begin
                  next_target = TGT_CAL;
                  next_is_read = 1'b0;
                  next_first_wr = 1'b1;
                end
                ADC_WR_ADDR: begin
                  next_target = TGT_ADC;
                  next_is_read = 1'b0;
                end
                ADC_RD_ADDR: begin
                  next_target = TGT_ADC;
                  next_is_read = 1'b1;
                  next_rd_idx = RESULT_HIGH;
                end
                default: begin
                  next_state = ST_IDLE;
                  next_drive = 1'b0;
                end
              endcase
            end else if (target == TGT_CAL) begin
              // only the byte address is taken, data writes refused
              if (first_wr) begin
                next_ptr = shift;
                next_first_wr = 1'b0;
              end else begin
                next_state = ST_IDLE;
                next_drive = 1'b0;
              end
            end else begin
              case (shift)
                CMD_PREFIX: next_armed = 1'b1;
                CMD_PRESSURE: begin
                  if (armed) begin
                    next_pend = 1'b1;
                    next_pend_kind = CONV_PRESSURE;
                  end else begin
                    next_state = ST_IDLE;
                    next_drive = 1'b0;
                  end
                  next_armed = 1'b0;
                end
                CMD_TEMPERATURE: begin
                  next_pend = 1'b1;
                  next_pend_kind = CONV_TEMPERATURE;
                  next_armed = 1'b0;
                end
                CMD_RESULT: next_armed = 1'b0;
                default: begin
                  next_state = ST_IDLE;
                  next_drive = 1'b0;
                  next_armed = 1'b0;
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_cnt = '0;
            if (is_read) begin
              next_state = ST_RD_BYTE;
              next_shift = load_byte;
              next_drive = !load_byte[7];
              if (target == TGT_CAL) begin
                next_ptr = ptr + 8'h01;
              end else if (rd_idx != RESULT_DONE) begin
                next_rd_idx = rd_idx + 2'h1;
              end
            end else begin
              next_state = ST_WR_BYTE;
              next_drive = 1'b0;
            end
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (cnt == LAST_BIT) begin
              next_state = ST_MACK;
              next_drive = 1'b0;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_drive = !shift[6];
              next_cnt = cnt + 4'h1;
            end
          end
        end
        ST_MACK: begin
          // master ack kept in shift[0]; a one ends the read
          if (scl_rise) begin
            next_shift = {shift[7:1], sync2.sda};
          end else if (scl_fall) begin
            if (!shift[0]) begin
              next_state = ST_RD_BYTE;
              next_cnt = '0;
              next_shift = load_byte;
              next_drive = !load_byte[7];
              if (target == TGT_CAL) begin
                next_ptr = ptr + 8'h01;
              end else if (rd_idx != RESULT_DONE) begin
                next_rd_idx = rd_idx + 2'h1;
              end
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_drive = 1'b0;
        end
      endcase
    end
  end

  // register the protocol engine
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      target <= TGT_CAL;
      is_read <= 1'b0;
      first_wr <= 1'b0;
      shift <= '0;
      cnt <= '0;
      ptr <= '0;
      rd_idx <= RESULT_HIGH;
      drive <= 1'b0;
      armed <= 1'b0;
      pend <= 1'b0;
      pend_kind <= CONV_PRESSURE;
    end else begin
      state <= next_state;
      target <= next_target;
      is_read <= next_is_read;
      first_wr <= next_first_wr;
      shift <= next_shift;
      cnt <= next_cnt;
      ptr <= next_ptr;
      rd_idx <= next_rd_idx;
      drive <= next_drive;
      armed <= next_armed;
      pend <= next_pend;
      pend_kind <= next_pend_kind;
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n_out = !drive;

endmodule
`default_nettype wire

// *** bench/pressure_readout_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module pressure_readout_asserts #(
  parameter int unsigned CONV_EDGES = 8
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // bus and converter pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic conv_clk_in,
  input wire logic converter_reset_n_in,
  input wire logic conv_busy_out
);
  default clocking dc @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // --------
  // converter clock rises seen during a conversion
  // --------
  logic clk_q;
  logic [15:0] edges;
  logic [15:0] next_edges;
  always_comb begin
    next_edges = edges;
    if (!conv_busy_out) next_edges = '0;
    else if (conv_clk_in && !clk_q) next_edges = edges + 16'h0001;
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_q <= 1'b0;
      edges <= '0;
    end else begin
      clk_q <= conv_clk_in;
      edges <= next_edges;
    end
  end
  // steps of a transfer as seen on the pins
  sequence bus_idle;
    scl_in && sda_in;
  endsequence
  sequence drive_begins;
    $fell(sda_oe_n_out);
  endsequence
  // pin may only pull low, never push high
  a_open_drain_low: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_drive_scl_low: assert property (drive_begins |-> !scl_in)
    else $error("data drive began with clock high");
  a_drive_holds_high: assert property
    ($rose(scl_in) |=> $stable(sda_oe_n_out) [*6])
    else $error("data drive moved while clock high");
  a_conv_from_idle: assert property
    ($rose(conv_busy_out) |-> bus_idle)
    else $error("conversion began outside a stop");
  // sync delay on the reset pin, so look a few cycles back as well
  a_conv_needs_converter_reset_n: assert property
    ($rose(conv_busy_out) |->
      converter_reset_n_in || $past(converter_reset_n_in, 4))
    else $error("conversion began under converter reset");
  a_converter_reset_n_stops_conv: assert property
    ($fell(converter_reset_n_in) |-> ##[0:6] !conv_busy_out)
    else $error("busy outlived converter reset");
  a_conv_len_max: assert property
    (conv_busy_out |-> edges <= CONV_EDGES + 1)
    else $error("conversion ran too many clock edges");
  a_conv_len_min: assert property
    ($fell(conv_busy_out) && converter_reset_n_in |->
      edges >= CONV_EDGES - 1)
    else $error("conversion ended too early");
endmodule
bind pressure_readout pressure_readout_asserts #(
  .CONV_EDGES(CONV_EDGES)
) u_asserts (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .conv_clk_in(conv_clk_in), .conv_busy_out(conv_busy_out),
  .converter_reset_n_in(converter_reset_n_in)
);
`default_nettype wire

// *** bench/bus_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module bus_master_model #(
  parameter int Q = 12
) (
  // pacing clock
  input wire logic mclk_in,
  // resolved data line
  input wire logic sda_in,
  // bus lines; a 1 on sda_out releases the pulled-up line
  output logic scl_out,
  output logic sda_out
);
  // --------
  // bit level, all changes at falling mclk edges
  // --------
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_out = 1'b1;
    tick(Q);
    scl_out = 1'b1;
    tick(Q);
    sda_out = 1'b0;
    tick(Q);
    scl_out = 1'b0;
    tick(Q);
  endtask
  task automatic stop();
    sda_out = 1'b0;
    tick(Q);
    scl_out = 1'b1;
    tick(Q);
    sda_out = 1'b1;
    tick(2 * Q);
  endtask
  // data set only while clock low, sampled mid high phase
  task automatic bitx(input logic b, output logic r);
    sda_out = b;
    tick(Q);
    scl_out = 1'b1;
    tick(Q);
    r = sda_in;
    tick(Q);
    scl_out = 1'b0;
    tick(Q);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // last byte answered with a released line
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(!ack, r);
  endtask
endmodule
`default_nettype wire

// *** bench/pressure_readout_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module pressure_readout_bench;
  import pressure_pkg::*;
  // boundary coefficients, unlike the defaults, so parameters must flow
  localparam logic [6:0][15:0] CO = {16'h0A28, 16'h4000, 16'h1000,
    16'h1000, 16'h0400, 16'h1FFF, 16'hFFFF};
  localparam logic [3:0][7:0] PA = {8'h0F, 8'h01, 8'h3F, 8'h2A};
  localparam logic [15:0] P_WORD = 16'h7554;
  localparam logic [15:0] T_WORD = 16'h100B;
  logic mclk_in, rstn_in, conv_clk_in, converter_reset_n_in;
  logic [15:0] raw_pressure_in, raw_temperature_in;
  logic scl, m_sda, sda_out, sda_oe_n_out, conv_busy_out, ack;
  logic [7:0] b;
  // table and result words as read back over the bus
  logic [6:0][15:0] co_rd;
  logic [3:0][7:0] pa_rd;
  logic [15:0] p_rd, t_rd;
  longint got, want;
  int errors = 0;
  int n_checks = 0;
  // wired-and of master and device
  wire logic sda_line = m_sda & (sda_oe_n_out | sda_out);
  pressure_readout #(.CONV_EDGES(8), .COEFFS(CO), .PARAMS(PA)) uut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .conv_clk_in(conv_clk_in), .converter_reset_n_in(converter_reset_n_in),
    .raw_pressure_in(raw_pressure_in),
    .raw_temperature_in(raw_temperature_in), .conv_busy_out(conv_busy_out));
  bus_master_model #(.Q(12)) mst (.mclk_in(mclk_in), .sda_in(sda_line),
    .scl_out(scl), .sda_out(m_sda));
  // --------
  // clocks; converter clock free running, phase unrelated
  // --------
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  initial begin
    conv_clk_in = 1'b0;
    forever #32 conv_clk_in = ~conv_clk_in;
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // start, address byte, expected answer
  task automatic addr(input logic [7:0] a, input logic exp_ack);
    mst.start();
    mst.wbyte(a, ack);
    check("address ack", {15'h0, ack}, {15'h0, exp_ack});
  endtask
  task automatic wr(input logic [7:0] d, input logic exp_ack);
    mst.wbyte(d, ack);
    check("data ack", {15'h0, ack}, {15'h0, exp_ack});
  endtask
  task automatic rd(input logic a, input logic [7:0] exp);
    mst.rbyte(a, b);
    check("read byte", {8'h0, b}, {8'h0, exp});
  endtask
  // bounded wait for the busy flag to reach a level
  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (conv_busy_out !== lvl && k < lim) begin
      @(negedge mclk_in);
      k++;
    end
    check("busy", {15'h0, conv_busy_out}, {15'h0, lvl});
  endtask
  // master arithmetic; 0 pressure, 1 finer pressure, 2 temperature
  function automatic longint comp(input logic [6:0][15:0] c,
      input logic [3:0][7:0] p, input logic [15:0] d1, d2, input int sel);
    longint dt, k, off, sensitivity, x;
    dt = longint'(d2) - longint'(c[4]);
    k = (dt < 0) ? longint'(p[1]) : longint'(p[0]);
    dt = dt - dt * dt / 16384 * k / (longint'(1) << p[2]);
    off = longint'(c[3]) - 1024;
    off = (longint'(c[1]) + off * dt / 16384) * 4;
    sensitivity = longint'(c[0]) + longint'(c[2]) * dt / 1024;
    x = sensitivity * (longint'(d1) - 7168) / 16384 - off;
    if (sel == 0) begin
      comp = x * 10 / 32 + longint'(c[6]);
    end else if (sel == 1) begin
      comp = x * 100 / 32 + longint'(c[6]) * 10;
    end else begin
      comp = 250 + dt * longint'(c[5]) / 65536;
      comp = comp - dt / (longint'(1) << p[3]);
    end
  endfunction
  // --------
  // main sequence
  // --------
  initial begin
    rstn_in = 1'b0;
    converter_reset_n_in = 1'b0;
    raw_pressure_in = P_WORD;
    raw_temperature_in = T_WORD;
    repeat (10) @(negedge mclk_in);
    rstn_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    // pointer set, a stray data byte refused, then the whole table
    addr(CAL_WR_ADDR, 1'b1);
    wr(SENSITIVITY_COEFF, 1'b1);
    wr(8'h5A, 1'b0);
    addr(CAL_RD_ADDR, 1'b1);
    for (int i = 0; i < 7; i++) begin
      rd(1'b1, CO[i][15:8]);
      co_rd[i][15:8] = b;
      rd(1'b1, CO[i][7:0]);
      co_rd[i][7:0] = b;
    end
    for (int i = 0; i < 4; i++) begin
      rd(1'b1, PA[i]);
      pa_rd[i] = b;
    end
    rd(1'b0, CAL_UNMAPPED);
    mst.stop();
    addr(8'h42, 1'b0);
    mst.stop();
    converter_reset_n_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    // command without prefix, then an unknown one: no conversion
    addr(ADC_WR_ADDR, 1'b1);
    wr(CMD_PRESSURE, 1'b0);
    mst.stop();
    addr(ADC_WR_ADDR, 1'b1);
    wr(8'h12, 1'b0);
    mst.stop();
    repeat (30) @(negedge mclk_in);
    check("idle", {15'h0, conv_busy_out}, 16'h0);
    addr(ADC_WR_ADDR, 1'b1);
    wr(CMD_PREFIX, 1'b1);
    wr(CMD_PRESSURE, 1'b1);
    mst.stop();
    wait_busy(1'b1, 40);
    wait_busy(1'b0, 400);
    // word must be the one captured at the end of conversion
    raw_pressure_in = 16'hFFFF;
    addr(ADC_WR_ADDR, 1'b1);
    wr(CMD_RESULT, 1'b1);
    addr(ADC_RD_ADDR, 1'b1);
    rd(1'b1, P_WORD[15:8]);
    rd(1'b0, P_WORD[7:0]);
    mst.stop();
    addr(ADC_WR_ADDR, 1'b1);
    wr(CMD_TEMPERATURE, 1'b1);
    mst.stop();
    wait_busy(1'b1, 40);
    wait_busy(1'b0, 400);
    raw_temperature_in = 16'h0000;
    addr(ADC_WR_ADDR, 1'b1);
    addr(ADC_RD_ADDR, 1'b1);
    rd(1'b1, T_WORD[15:8]);
    t_rd[15:8] = b;
    rd(1'b0, T_WORD[7:0]);
    t_rd[7:0] = b;
    mst.stop();
    // first pressure result is dropped; the second one feeds the maths
    raw_pressure_in = P_WORD;
    addr(ADC_WR_ADDR, 1'b1);
    wr(CMD_PREFIX, 1'b1);
    wr(CMD_PRESSURE, 1'b1);
    mst.stop();
    wait_busy(1'b1, 40);
    wait_busy(1'b0, 400);
    addr(ADC_WR_ADDR, 1'b1);
    wr(CMD_RESULT, 1'b1);
    addr(ADC_RD_ADDR, 1'b1);
    rd(1'b1, P_WORD[15:8]);
    p_rd[15:8] = b;
    rd(1'b0, P_WORD[7:0]);
    p_rd[7:0] = b;
    mst.stop();
    // arithmetic on what came over the bus against the table constants
    for (int s = 0; s < 3; s++) begin
      got = comp(co_rd, pa_rd, p_rd, t_rd, s);
      want = comp(CO, PA, P_WORD, T_WORD, s);
      check("compensated", got[15:0], want[15:0]);
    end
    // converter reset pulled mid conversion aborts it, clears the word
    addr(ADC_WR_ADDR, 1'b1);
    wr(CMD_TEMPERATURE, 1'b1);
    mst.stop();
    wait_busy(1'b1, 40);
    converter_reset_n_in = 1'b0;
    wait_busy(1'b0, 8);
    // a command under converter reset starts nothing
    addr(ADC_WR_ADDR, 1'b1);
    wr(CMD_TEMPERATURE, 1'b1);
    mst.stop();
    check("held", {15'h0, conv_busy_out}, 16'h0);
    addr(ADC_WR_ADDR, 1'b1);
    addr(ADC_RD_ADDR, 1'b1);
    rd(1'b1, 8'h00);
    rd(1'b0, 8'h00);
    mst.stop();
    conclude();
  end
  // watchdog, well beyond the expected run of some 30000 cycles
  initial begin
    repeat (60000) @(posedge mclk_in);
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
